// ==== hw/compact_timer_defs.vh ====
`ifndef COMPACT_TIMER_DEFS_VH
`define COMPACT_TIMER_DEFS_VH

// Register word byte addresses on the APB port.
`define CT_ADDR_CTRL0 12'h000
`define CT_ADDR_CTRL1 12'h004
`define CT_ADDR_CNT_LO 12'h008
`define CT_ADDR_CNT_HI 12'h00c
`define CT_ADDR_CMPA_LO 12'h010
`define CT_ADDR_CMPA_HI 12'h014
`define CT_ADDR_STATUS 12'h018

// Control zero fields.
`define CT_C0_PAUSE 7
`define CT_C0_CKSEL_HI 6
`define CT_C0_CKSEL_LO 4
`define CT_C0_ON 3
`define CT_C0_PER_HI 2
`define CT_C0_PER_LO 0

// Control one fields.
`define CT_C1_MODE_HI 7
`define CT_C1_MODE_LO 6
`define CT_C1_PIN_HI 5
`define CT_C1_PIN_LO 4
`define CT_C1_INIT 3
`define CT_C1_INV 2
`define CT_C1_SWAP 1
`define CT_C1_CLRSEL 0

// Status fields, write one to clear.
`define CT_ST_MATCH_A 0
`define CT_ST_MATCH_P 1

// Mode encodings.
`define CT_MODE_CMP 2'h0
`define CT_MODE_PWM 2'h2
`define CT_MODE_TMR 2'h3

// Compare match pin actions.
`define CT_PIN_NONE 2'h0
`define CT_PIN_LOW 2'h1
`define CT_PIN_HIGH 2'h2
`define CT_PIN_TOGGLE 2'h3

// PWM pin actions.
`define CT_PWM_INACTIVE 2'h0
`define CT_PWM_ACTIVE 2'h1
`define CT_PWM_WAVE 2'h2

// Clock select encodings.
`define CT_CK_DIV4 3'h0
`define CT_CK_DIV1 3'h1
`define CT_CK_DIV16 3'h2
`define CT_CK_DIV64 3'h3

// Reset values and counter maximum.
`define CT_CTRL0_RST 8'h00
`define CT_CTRL1_RST 8'h00
`define CT_CMPA_RST 10'h000
`define CT_CNT_MAX 10'h3ff

`endif

// ==== hw/compact_timer.v ====
// Summary of operation
// - Count high byte returns bits nine, eight.
// - Compare A ten bits, two bytes, reset zero.
// - Mode 00 compare, 10 PWM, 11 timer.
// - Clear on P match or overflow; both flags, P flag only on match.
// - Clear on A match; P flag never set.
// - Compare A zero overflows, no A flag.
// - Pin changes only on A match.
// - Pin action high, low, toggle, or none.
// - Counter on rising edge loads initial level.
// - Timer mode counts like compare, pin unused.
// - PWM ignores clear select; swap picks period.
// - PWM raises A and P flags on matches.
// - PWM polarity from initial level, action enables.
// - Output invert flips the driven pin level.
// - Swap zero: period P times 128, duty A.
// - Duty at or above period gives full duty.
// - Swap one: period A, duty P times 128.
// - PWM counting continues while pin forced.
// - Period compares with counter top three bits.
// - On rising clears counter; falling holds count.
// - PWM action 00 inactive, 01 active, 10 wave.
`timescale 1ns/1ps
`include "compact_timer_defs.vh"

module compact_timer (
  input wire pclk, // APB clock, 100 MHz
  input wire presetn, // asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire ext_clk_in, // external count clock pin
  output wire timer_out, // timer output pin level
  output wire timer_out_en, // high while the timer owns the pin
  output wire match_a_flag, // sticky comparator A flag
  output wire match_p_flag // sticky comparator P flag
);

  reg [7:0] ctrl0_reg;
  reg [7:0] ctrl1_reg;
  reg [9:0] cmpa_reg;
  reg [9:0] count_reg;
  reg [9:0] count_next;
  reg pin_reg;
  reg pin_next;
  reg flag_a_reg;
  reg flag_p_reg;
  reg on_d_reg;
  reg clear_pend_reg;
  reg clear_pend_next;
  reg [5:0] div_reg;
  reg ext_d_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;

  wire [1:0] mode = ctrl1_reg[`CT_C1_MODE_HI:`CT_C1_MODE_LO];
  wire [1:0] pin_sel = ctrl1_reg[`CT_C1_PIN_HI:`CT_C1_PIN_LO];
  wire [2:0] period_val = ctrl0_reg[`CT_C0_PER_HI:`CT_C0_PER_LO];
  wire [2:0] ck_sel = ctrl0_reg[`CT_C0_CKSEL_HI:`CT_C0_CKSEL_LO];
  wire counter_on = ctrl0_reg[`CT_C0_ON];
  wire paused = ctrl0_reg[`CT_C0_PAUSE];
  wire init_level = ctrl1_reg[`CT_C1_INIT];
  wire out_inv = ctrl1_reg[`CT_C1_INV];
  wire swap = ctrl1_reg[`CT_C1_SWAP];
  wire clr_sel = ctrl1_reg[`CT_C1_CLRSEL];
  wire is_pwm = (mode == `CT_MODE_PWM);

  // Slower rates come from one free-running divider; each is a one-cycle enable.
  // The low-speed sources share the divide-by-64 tap since no sub clock exists here.
  function tick_sel;
    input [2:0] sel;
    input [5:0] div;
    input ext_now;
    input ext_prev;
    begin
      case (sel)
        `CT_CK_DIV4: tick_sel = (div[1:0] == 2'h3);
        `CT_CK_DIV1: tick_sel = 1'b1;
        `CT_CK_DIV16: tick_sel = (div[3:0] == 4'hf);
        3'h6: tick_sel = ext_now & ~ext_prev;
        3'h7: tick_sel = ~ext_now & ext_prev;
        default: tick_sel = (div == 6'h3f);
      endcase
    end
  endfunction

  wire apb_wr = psel & penable & pwrite;
  wire on_rise = counter_on & ~on_d_reg;
  wire tick = tick_sel(ck_sel, div_reg, ext_clk_in, ext_d_reg);
  wire run = counter_on & ~paused & tick;

  // Comparator P looks only at the top three counter bits.
  wire match_p = (count_reg[9:7] == period_val);
  wire match_a = (count_reg == cmpa_reg);
  wire at_max = (count_reg == `CT_CNT_MAX);
  // A zero period means the counter wraps at its maximum instead.
  wire p_clear = (period_val == 3'h0) ? at_max : match_p;
  wire a_clear = (cmpa_reg == 10'h000) ? at_max : match_a;
  // Match events fire once per count, on the tick that leaves the value.
  wire ev_a = run & match_a & (cmpa_reg != 10'h000) & ~clear_pend_reg;
  wire ev_p = run & match_p & (period_val != 3'h0) & ~clear_pend_reg;

  wire [9:0] period_cnt = {period_val, 7'h00};
  // In PWM the swap bit picks the clearing comparator.
  wire pwm_clr = swap ? a_clear : p_clear;
  wire clear_now = is_pwm ? pwm_clr : (clr_sel ? a_clear : p_clear);

  // PWM duty: active while the counter is below the duty value.
  reg duty_active;
  always @* begin
    if (swap) begin
      if (period_val == 3'h0)
        duty_active = 1'b1;
      else if ((cmpa_reg != 10'h000) && (period_cnt >= cmpa_reg))
        duty_active = 1'b1;
      else
        duty_active = (count_reg < period_cnt);
    end else begin
      if ((period_val != 3'h0) && (cmpa_reg >= period_cnt))
        duty_active = 1'b1;
      else
        duty_active = (count_reg < cmpa_reg);
    end
  end

  // Counter; a clear takes effect on the next count tick.
  always @* begin
    count_next = count_reg;
    clear_pend_next = clear_pend_reg;
    if (on_rise) begin
      count_next = 10'h000;
      clear_pend_next = 1'b0;
    end else if (run) begin
      if (clear_pend_reg) begin
        count_next = 10'h000;
        clear_pend_next = 1'b0;
      end else begin
        count_next = count_reg + 10'h001;
        clear_pend_next = clear_now & ~at_max;
        if (clear_now & at_max)
          count_next = 10'h000;
      end
    end
  end

  // Pin state for compare mode and PWM; timer mode only loads the initial level when the counter starts.
  always @* begin
    pin_next = pin_reg;
    if (on_rise) begin
      pin_next = init_level;
    end else if (mode == `CT_MODE_CMP && ev_a) begin
      case (pin_sel)
        `CT_PIN_LOW: pin_next = 1'b0;
        `CT_PIN_HIGH: pin_next = 1'b1;
        `CT_PIN_TOGGLE: pin_next = ~pin_reg;
        default: pin_next = pin_reg;
      endcase
    end else if (is_pwm && counter_on) begin
      case (pin_sel)
        `CT_PWM_INACTIVE: pin_next = ~init_level;
        `CT_PWM_ACTIVE: pin_next = init_level;
        `CT_PWM_WAVE: pin_next = duty_active ? init_level : ~init_level;
        default: pin_next = pin_reg;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `CT_CTRL0_RST;
      ctrl1_reg <= `CT_CTRL1_RST;
      cmpa_reg <= `CT_CMPA_RST;
      count_reg <= 10'h000;
      clear_pend_reg <= 1'b0;
      pin_reg <= 1'b0;
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
      on_d_reg <= 1'b0;
      div_reg <= 6'h00;
      ext_d_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      div_reg <= div_reg + 6'h01;
      ext_d_reg <= ext_clk_in;
      on_d_reg <= counter_on;
      count_reg <= count_next;
      clear_pend_reg <= clear_pend_next;
      pin_reg <= pin_next;
      rdata_reg <= rdata_next;
      if (apb_wr) begin
        case (paddr)
          `CT_ADDR_CTRL0: ctrl0_reg <= pwdata[7:0];
          `CT_ADDR_CTRL1: ctrl1_reg <= pwdata[7:0];
          `CT_ADDR_CMPA_LO: cmpa_reg[7:0] <= pwdata[7:0];
          `CT_ADDR_CMPA_HI: cmpa_reg[9:8] <= pwdata[1:0];
          default: ;
        endcase
      end
      // A new match wins over a write-one clear in the same cycle.
      if (ev_a)
        flag_a_reg <= 1'b1;
      else if (apb_wr && paddr == `CT_ADDR_STATUS && pwdata[`CT_ST_MATCH_A])
        flag_a_reg <= 1'b0;
      if (ev_p && (is_pwm || !clr_sel))
        flag_p_reg <= 1'b1;
      else if (apb_wr && paddr == `CT_ADDR_STATUS && pwdata[`CT_ST_MATCH_P])
        flag_p_reg <= 1'b0;
    end
  end

  // Read data is registered in the setup cycle, so the access phase needs no wait.
  always @* begin
    rdata_next = 32'h00000000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `CT_ADDR_CTRL0: rdata_next = {24'h000000, ctrl0_reg};
        `CT_ADDR_CTRL1: rdata_next = {24'h000000, ctrl1_reg};
        `CT_ADDR_CNT_LO: rdata_next = {24'h000000, count_reg[7:0]};
        `CT_ADDR_CNT_HI: rdata_next = {30'h0, count_reg[9:8]};
        `CT_ADDR_CMPA_LO: rdata_next = {24'h000000, cmpa_reg[7:0]};
        `CT_ADDR_CMPA_HI: rdata_next = {30'h0, cmpa_reg[9:8]};
        `CT_ADDR_STATUS: rdata_next = {30'h0, flag_p_reg, flag_a_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  wire mapped = (paddr == `CT_ADDR_CTRL0) || (paddr == `CT_ADDR_CTRL1) ||
                (paddr == `CT_ADDR_CNT_LO) || (paddr == `CT_ADDR_CNT_HI) ||
                (paddr == `CT_ADDR_CMPA_LO) || (paddr == `CT_ADDR_CMPA_HI) ||
                (paddr == `CT_ADDR_STATUS);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_reg;
  assign timer_out = pin_reg ^ out_inv;
  assign timer_out_en = (mode != `CT_MODE_TMR) & (mode != 2'h1);
  assign match_a_flag = flag_a_reg;
  assign match_p_flag = flag_p_reg;

endmodule // compact_timer

// ==== test/compact_timer_checker.sv ====
`timescale 1ns/1ps
module compact_timer_checker (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // access phase
  input wire pwrite, // write
  input wire [11:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire ext_clk_in, // count pin
  input wire timer_out, // pin level
  input wire timer_out_en, // pin enable
  input wire match_a_flag, // A flag
  input wire match_p_flag // P flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  reg [7:0] ctrl0_reg;
  reg [7:0] ctrl1_reg;
  reg [9:0] cmpa_reg;
  // Shadows follow the edge that commits a write, so they agree with the block's own registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= 8'h00;
      ctrl1_reg <= 8'h00;
      cmpa_reg <= 10'h000;
    end else if (wr) begin
      if (paddr == 12'h000)
        ctrl0_reg <= pwdata[7:0];
      if (paddr == 12'h004)
        ctrl1_reg <= pwdata[7:0];
      if (paddr == 12'h010)
        cmpa_reg[7:0] <= pwdata[7:0];
      if (paddr == 12'h014)
        cmpa_reg[9:8] <= pwdata[1:0];
    end
  end
  sequence pwm_forced;
    (ctrl0_reg[3] && ctrl1_reg[7:5] == 3'h4 && $stable(ctrl1_reg))[*3];
  endsequence
  AST_CNT_HI: assert property (rd && paddr == 12'h00c |-> prdata[31:2] == 30'h0)
    else $error("count high byte upper bits set");
  AST_CMPA_HI: assert property (rd && paddr == 12'h014 |-> prdata == {30'h0, cmpa_reg[9:8]})
    else $error("compare high byte wrong");
  AST_CMPA_LO: assert property (rd && paddr == 12'h010 |-> prdata == {24'h0, cmpa_reg[7:0]})
    else $error("compare low byte wrong");
  AST_PIN_EN: assert property (timer_out_en == (ctrl1_reg[7:6] == 2'h0 || ctrl1_reg[7:6] == 2'h2))
    else $error("pin enable wrong for mode");
  AST_INIT: assert property ($rose(ctrl0_reg[3]) && ctrl1_reg[7:6] == 2'h0
    |=> timer_out == (ctrl1_reg[3] ^ ctrl1_reg[2])) else $error("pin not at initial level");
  AST_INV: assert property (!ctrl0_reg[3] && $changed(ctrl1_reg[2]) |-> timer_out != $past(timer_out))
    else $error("invert did not flip pin");
  AST_NO_PF: assert property (ctrl1_reg[7:6] != 2'h2 && ctrl1_reg[0] && !match_p_flag
    |=> !match_p_flag) else $error("P flag set with clear on A");
  AST_NO_AF: assert property (cmpa_reg == 10'h000 && !match_a_flag |=> !match_a_flag)
    else $error("A flag set with compare zero");
  AST_P_ZERO: assert property (ctrl0_reg[2:0] == 3'h0 && !match_p_flag |=> !match_p_flag)
    else $error("P flag set with period zero");
  AST_FORCE: assert property (pwm_forced |-> timer_out == (ctrl1_reg[3] ^ !ctrl1_reg[4] ^ ctrl1_reg[2]))
    else $error("forced pin level wrong");
endmodule // compact_timer_checker

bind compact_timer compact_timer_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in), .timer_out(timer_out),
  .timer_out_en(timer_out_en), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, timer_out, timer_out_en, match_a_flag, match_p_flag;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer n, i;
  reg [31:0] rd;
  reg [31:0] keep;
  reg err;
  always #5 pclk = ~pclk;
  compact_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(1'b0), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
  task finish_test;
    begin
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [8*16-1:0] msg);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: %0s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask
  // Read data and error are taken at the edge that completes the access, then released.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n >= 50) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: no ready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "register read");
    end
  endtask
  task restart(input [31:0] c1);
    begin
      wr(12'h000, 32'h10);
      wr(12'h004, c1);
      wr(12'h018, 32'h3);
      wr(12'h000, 32'h19);
    end
  endtask
  task pwm(input [31:0] c1, input integer lo, input integer hi);
    begin
      restart(c1);
      repeat (20) @(posedge pclk);
      i = 0;
      repeat (260) begin
        @(negedge pclk);
        if (timer_out === 1'b1)
          i = i + 1;
      end
      chk(i >= lo && i <= hi, 1, "pwm high count");
      $display("pwm test %h done", c1);
    end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h010, 0);
    rdc(12'h014, 0);
    rdc(12'h00c, 0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 1, "unmapped error");
    wr(12'h010, 32'h1ff);
    rdc(12'h010, 32'hff);
    wr(12'h014, 32'hff);
    rdc(12'h014, 32'h3);
    wr(12'h014, 32'h0);
    wr(12'h010, 32'h5);
    $display("register test done");
    restart(32'h30);
    repeat (350) @(posedge pclk);
    chk(match_a_flag & match_p_flag, 1, "both flags");
    chk(timer_out, 1, "toggle on A");
    rdc(12'h00c, 0);
    wr(12'h010, 32'h0);
    wr(12'h014, 32'h2);
    restart(32'h21);
    repeat (600) @(posedge pclk);
    chk(match_p_flag, 0, "no P flag");
    chk(match_a_flag, 1, "A flag");
    chk(timer_out, 1, "high on A");
    wr(12'h014, 32'h0);
    restart(32'h21);
    repeat (900) @(posedge pclk);
    rdc(12'h00c, 32'h3);
    chk(match_a_flag, 0, "no A flag");
    wr(12'h010, 32'h5);
    restart(32'hc0);
    repeat (400) @(posedge pclk);
    chk(match_a_flag & match_p_flag, 1, "timer flags");
    chk(timer_out_en, 0, "pin released");
    wr(12'h000, 32'h99);
    apb(1'b0, 12'h008, 32'h0);
    keep = rd;
    repeat (20) @(posedge pclk);
    rdc(12'h008, keep);
    $display("compare and timer tests done");
    wr(12'h010, 32'h20);
    pwm(32'ha8, 64, 66);
    chk(match_a_flag & match_p_flag, 1, "pwm flags");
    pwm(32'hac, 194, 196);
    pwm(32'h88, 0, 0);
    chk(match_p_flag, 1, "forced counting");
    pwm(32'h98, 260, 260);
    wr(12'h014, 32'h3);
    pwm(32'ha8, 260, 260);
    wr(12'h014, 32'h1);
    wr(12'h010, 32'h0);
    pwm(32'haa, 126, 134);
    finish_test;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule // tb
